/* hw/msd_regs.vh */
// Summary of operation
// - strap pins low/low mode 0, low/high 1, high/low 2, high/high 3
// - straps captured as reset releases, held until next reset
// - mode 0 is programming only, no normal execution decode
// - the no-rom variant runs only in mode 1
// - mode 1 maps nearly all space off-chip, rom and shared memory unused
// - mode 2 maps first 16k to rom, other non-internal addresses external
// - expanded modes: ports 1,2 address, port 3 data, p8.1 p9.7/5/4/3 control
// - single-chip mode drives no address bus, ports 1 and 2 general purpose
// - single-chip shared memory: port 3 data, p8.0-3 select, p9 pins interface
// - single-chip off-chip access raises no error and reads all ones
// - rom and ram word access in two states, register field byte in three
// - external access bytewise, three states plus requested wait states
// - expanded modes decode ff80-ff8f and ffa8-ffaf off-chip
// - io page strobe low for accesses ff00-ffff, high otherwise
// - register field occupies ff90-ffa7 and ffb0-ffff
// - memory enable set: ram at fd80-ff7f; clear: that range external, except single-chip keeps ram there
// - reset sets memory enable bit 0 to one, standby leaves it unchanged
// - shared enable bit 1 resets zero; slave mode only in single-chip
// - shared memory enabled: both masters reach it; disabled: internal only
// - readback bits 7-5 and 2 read one, 4 and 3 zero, writes ignored
// - readback bits 1 and 0 show latched straps, read only
`ifndef MSD_REGS_VH
`define MSD_REGS_VH
`define MSD_SYSCFG_ADDR   16'hffc4
`define MSD_READBACK_ADDR 16'hffc5
`define MSD_SYSCFG_RST    8'h09
`define MSD_SYSCFG_WMASK  8'hf7
`define MSD_READBACK_FIX  8'he4
`define MSD_ONCHIP_MEMORY_ENABLE_BIT      0
`define MSD_SHARED_MEMORY_ENABLE_BIT      1
`define MSD_MODE_PROG     2'b00
`define MSD_MODE_EXP_NOROM 2'b01
`define MSD_MODE_EXP_ROM  2'b10
`define MSD_MODE_SINGLE   2'b11
`define MSD_ROM_END       16'h3fff
`define MSD_RAM_BASE      16'hfd80
`define MSD_RAM_END       16'hff7f
`define MSD_GAP0_BASE     16'hff80
`define MSD_GAP0_END      16'hff8f
`define MSD_GAP1_BASE     16'hffa8
`define MSD_GAP1_END      16'hffaf
`define MSD_IOPAGE_BASE   16'hff00
`define MSD_ST_ONCHIP     3'd2
`define MSD_ST_REGFIELD   3'd3
`define MSD_ST_EXTERNAL   3'd3
`define MSD_DEC_NONE      3'd0
`define MSD_DEC_ROM       3'd1
`define MSD_DEC_RAM       3'd2
`define MSD_DEC_REG       3'd3
`define MSD_DEC_EXT       3'd4
`define MSD_DEC_VOID      3'd5
`endif

/* hw/msd_decode.v */
`timescale 1ns/1ps
`include "msd_regs.vh"
// purely combinational region decode of one cpu address
module msd_decode (
  input  wire [1:0]  mode,         // latched operating mode
  input  wire        ram_en,       // on-chip memory enable
  input  wire        rom_present,  // part carries on-chip rom
  input  wire [15:0] addr,         // cpu address
  output reg  [2:0]  region,       // decoded region code
  output wire        io_page       // address is within ff00-ffff
);
  function in_rng;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  assign io_page = (addr >= `MSD_IOPAGE_BASE);

  // priority: register field, gaps, ram, rom, external
  always @* begin
    region = `MSD_DEC_EXT;
    if (mode == `MSD_MODE_PROG) begin
      region = `MSD_DEC_NONE;
    end else if (addr >= `MSD_IOPAGE_BASE && addr > `MSD_GAP0_END &&
                 !in_rng(addr, `MSD_GAP1_BASE, `MSD_GAP1_END)) begin
      region = `MSD_DEC_REG;
    end else if (in_rng(addr, `MSD_GAP0_BASE, `MSD_GAP0_END) ||
                 in_rng(addr, `MSD_GAP1_BASE, `MSD_GAP1_END)) begin
      region = (mode == `MSD_MODE_SINGLE) ? `MSD_DEC_VOID : `MSD_DEC_EXT;
    end else if (in_rng(addr, `MSD_RAM_BASE, `MSD_RAM_END) &&
                 (ram_en || mode == `MSD_MODE_SINGLE)) begin
      region = `MSD_DEC_RAM;
    end else if (addr <= `MSD_ROM_END && mode != `MSD_MODE_EXP_NOROM && rom_present) begin
      region = `MSD_DEC_ROM;
    end else if (mode == `MSD_MODE_SINGLE) begin
      region = `MSD_DEC_VOID;
    end else begin
      region = `MSD_DEC_EXT;
    end
  end
endmodule

/* hw/msd_timer.v */
`timescale 1ns/1ps
`include "msd_regs.vh"
// counts the states of one access and flags its last state
module msd_timer (
  input  wire       mclk,     // system clock
  input  wire       rst_b,    // async reset, active low
  input  wire       start,    // access begins this cycle
  input  wire [2:0] states,   // base states of this access
  input  wire       wait_req, // external wait request
  input  wire       is_ext,   // access goes external
  output wire       busy,     // access in progress
  output wire       last      // final state of the access
);
  reg [2:0] cnt_reg;
  reg       ext_reg;
  reg [2:0] cnt_next;

  // wait states stretch only external cycles, never internal ones
  assign last = (cnt_reg == 3'd1) && !(ext_reg && wait_req);
  assign busy = (cnt_reg != 3'd0);

  always @* begin
    cnt_next = cnt_reg;
    if (start && !busy)
      cnt_next = states;
    else if (busy && !(cnt_reg == 3'd1 && ext_reg && wait_req))
      cnt_next = cnt_reg - 3'd1;
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'd0;
      ext_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (start && !busy)
        ext_reg <= is_ext;
    end
  end
endmodule

/* hw/msd_top.v */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "msd_regs.vh"
// mode latch, address decode, bus pin usage and the two control registers
module msd_top #(
  parameter ROM_PRESENT = 1 // 0 models the variant without rom
) (
  input  wire        mclk,             // system clock
  input  wire        rst_b,            // chip init input, active low
  input  wire        mode_strap_high,  // mode strap, high bit
  input  wire        mode_strap_low,   // mode strap, low bit
  input  wire [15:0] reg_addr,         // register port address
  input  wire [7:0]  reg_wdata,        // register write data
  input  wire        reg_wr,           // register write strobe
  input  wire        reg_rd,           // register read strobe
  output reg  [7:0]  reg_rdata,        // register read data, one cycle later
  input  wire        cpu_req,          // cpu access request, level until done
  input  wire [15:0] cpu_addr,         // cpu access address
  input  wire        cpu_wait,         // external wait request
  output wire        cpu_done,         // final state of the access
  output wire        cpu_void,         // access hits no memory, data all ones
  output wire [2:0]  cpu_region,       // decoded region of current address
  output wire        io_page_strobe_n, // low while ff00-ffff is accessed
  output wire        addr_bus_en,      // ports 1 and 2 act as address bus
  output wire        data_bus_en,      // port 3 acts as external data bus
  output wire        bus_ctrl_en,      // p8.1 and p9.7/5/4/3 carry bus control
  output wire        slave_en,         // shared-memory slave pins active
  output wire        ext_master_ok,    // external master may reach shared memory
  output wire        mode_valid,       // mode is an executing mode
  output wire [1:0]  op_mode           // latched operating mode
);
  reg  [1:0] mode_reg;
  reg        cap_reg;
  reg  [7:0] syscfg_reg;
  reg  [7:0] syscfg_next;
  wire       onchip_memory_enable;
  wire       shared_memory_enable;
  wire [7:0] mode_readback_reg;
  wire       io_page;
  wire [2:0] base_states;
  wire       busy;

  // straps captured on the first clock after release; async reset may only
  // load constants, so a capture flag gates the one-time sample
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 2'b00;
      cap_reg  <= 1'b0;
    end else if (!cap_reg) begin
      mode_reg <= {mode_strap_high, mode_strap_low};
      cap_reg  <= 1'b1;
    end
  end

  // without rom only mode 1 runs; other straps are held non-executing
  assign op_mode    = mode_reg;
  assign mode_valid = cap_reg && (mode_reg != `MSD_MODE_PROG) &&
                      (ROM_PRESENT != 0 || mode_reg == `MSD_MODE_EXP_NOROM);

  assign onchip_memory_enable = syscfg_reg[`MSD_ONCHIP_MEMORY_ENABLE_BIT];
  assign shared_memory_enable = syscfg_reg[`MSD_SHARED_MEMORY_ENABLE_BIT];
  assign mode_readback_reg    = `MSD_READBACK_FIX | {6'h00, mode_reg};

  // bit 3 fixed at one; standby does not touch the register
  always @* begin
    syscfg_next = syscfg_reg;
    if (reg_wr && reg_addr == `MSD_SYSCFG_ADDR)
      syscfg_next = (reg_wdata & `MSD_SYSCFG_WMASK) | (`MSD_SYSCFG_RST & ~`MSD_SYSCFG_WMASK);
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      syscfg_reg <= `MSD_SYSCFG_RST;
    else
      syscfg_reg <= syscfg_next;
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == `MSD_SYSCFG_ADDR)
      reg_rdata <= syscfg_reg;
    else if (reg_rd && reg_addr == `MSD_READBACK_ADDR)
      reg_rdata <= mode_readback_reg;
    else
      reg_rdata <= 8'h00;
  end

  msd_decode u_dec (
    .mode        (mode_reg),
    .ram_en      (onchip_memory_enable),
    .rom_present (ROM_PRESENT != 0),
    .addr        (cpu_addr),
    .region      (cpu_region),
    .io_page     (io_page)
  );

  // state count per region; register field and external take three
  assign base_states = (cpu_region == `MSD_DEC_ROM || cpu_region == `MSD_DEC_RAM) ?
                       `MSD_ST_ONCHIP :
                       (cpu_region == `MSD_DEC_REG) ? `MSD_ST_REGFIELD :
                       `MSD_ST_EXTERNAL;

  msd_timer u_tim (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .start    (cpu_req && mode_valid),
    .states   (base_states),
    .wait_req (cpu_wait),
    .is_ext   (cpu_region == `MSD_DEC_EXT),
    .busy     (busy),
    .last     (cpu_done)
  );

  assign cpu_void         = cpu_region == `MSD_DEC_VOID;
  assign io_page_strobe_n = !(busy && io_page);

  // pin usage per mode; in mode 3 the port logic still owns direction
  assign addr_bus_en   = mode_valid && mode_reg != `MSD_MODE_SINGLE;
  assign data_bus_en   = addr_bus_en;
  assign bus_ctrl_en   = addr_bus_en;
  assign slave_en      = mode_valid && mode_reg == `MSD_MODE_SINGLE &&
                         shared_memory_enable && ROM_PRESENT != 0;
  assign ext_master_ok = slave_en;
endmodule

/* bench/msd_top_sva.sv */
`timescale 1ns/1ps
// decode, pin use and access timing relations seen at the top ports
module msd_top_sva (
  input wire        mclk, rst_b, reg_rd, cpu_done, cpu_void, io_page_strobe_n,
  input wire        addr_bus_en, data_bus_en, bus_ctrl_en, slave_en, mode_valid,
  input wire [15:0] reg_addr, cpu_addr,
  input wire [7:0]  reg_rdata,
  input wire [2:0]  cpu_region,
  input wire [1:0]  op_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_rdback;
    reg_rd && reg_addr == 16'hffc5 |=> reg_rdata == {6'b111001, op_mode};
  endproperty
  a_rdback: assert property (p_rdback) else $error("readback value wrong");
  property p_hold;
    mode_valid |=> $stable(op_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved after latch");
  property p_prog;
    mode_valid |-> op_mode != 2'b00;
  endproperty
  a_prog: assert property (p_prog) else $error("mode 0 executing");
  property p_pins;
    mode_valid && op_mode != 2'b11 |-> addr_bus_en && data_bus_en && bus_ctrl_en;
  endproperty
  a_pins: assert property (p_pins) else $error("expanded pins off");
  property p_gap;
    mode_valid && op_mode != 2'b11 && cpu_addr[15:4] == 12'hff8 |-> cpu_region == 3'd4;
  endproperty
  a_gap: assert property (p_gap) else $error("gap not external");
  property p_iop;
    !io_page_strobe_n |-> cpu_addr[15:8] == 8'hff;
  endproperty
  a_iop: assert property (p_iop) else $error("strobe outside io page");
  property p_void;
    mode_valid && op_mode == 2'b11 && cpu_addr[15:14] == 2'b01 |-> cpu_void;
  endproperty
  a_void: assert property (p_void) else $error("off-chip not void");
  property p_rf;
    $fell(io_page_strobe_n) && cpu_region == 3'd3 |-> !cpu_done ##1 !cpu_done ##1 cpu_done;
  endproperty
  a_rf: assert property (p_rf) else $error("register access not 3 states");
  c_ext: cover property (cpu_done && cpu_region == 3'd4);
  c_slv: cover property (slave_en);
  c_void: cover property (cpu_void);
endmodule
bind msd_top msd_top_sva i_sva (.mclk(mclk), .rst_b(rst_b), .reg_rd(reg_rd),
  .cpu_done(cpu_done), .cpu_void(cpu_void), .io_page_strobe_n(io_page_strobe_n),
  .addr_bus_en(addr_bus_en), .data_bus_en(data_bus_en), .bus_ctrl_en(bus_ctrl_en),
  .slave_en(slave_en), .mode_valid(mode_valid), .reg_addr(reg_addr),
  .cpu_addr(cpu_addr), .reg_rdata(reg_rdata), .cpu_region(cpu_region), .op_mode(op_mode));

/* bench/msd_ext_dev.sv */
`timescale 1ns/1ps
// external memory or io device that stretches its bus cycles
module msd_ext_dev (
  input  wire       mclk,    // system clock
  input  wire       rst_b,   // async reset, active low
  input  wire       sel,     // external access under way
  input  wire [3:0] stall,   // wait states asked for
  output wire       wait_req // wait request back
);
  reg [4:0] cnt_reg;
  // cycles of the current selection, restart on every new access
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cnt_reg <= 5'd0;
    else if (sel) cnt_reg <= cnt_reg + 5'd1;
    else cnt_reg <= 5'd0;
  end
  // held from the last base state so each wait adds exactly one state
  assign wait_req = sel && cnt_reg >= 5'd3 && cnt_reg < 5'd3 + {1'b0, stall};
endmodule

/* bench/test_mode_select_address_decode.sv */
`timescale 1ns/1ps
module test_mode_select_address_decode;
  reg         mclk, rst_b, hi, lo, wr_s, rd_s, req;
  reg  [15:0] ra, ca;
  reg  [7:0]  wd;
  reg  [3:0]  stall;
  wire [7:0]  rdat;
  wire [2:0]  rgn;
  wire [1:0]  opm;
  wire        wt, done, vd, ios_n, abus, dbus, cbus, slv, xok, mval;
  wire        mval2, slv2;
  integer     fail_count, cmp_count, m, i, n;
  reg  [95:0] tab = {16'h0000, 16'h4000, 16'hfd80, 16'hff80, 16'hff90, 16'hffa8};
  msd_top #(.ROM_PRESENT(1)) i_dut (.mclk(mclk), .rst_b(rst_b), .mode_strap_high(hi),
    .mode_strap_low(lo), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdat), .cpu_req(req), .cpu_addr(ca), .cpu_wait(wt), .cpu_done(done),
    .cpu_void(vd), .cpu_region(rgn), .io_page_strobe_n(ios_n), .addr_bus_en(abus),
    .data_bus_en(dbus), .bus_ctrl_en(cbus), .slave_en(slv), .ext_master_ok(xok),
    .mode_valid(mval), .op_mode(opm));
  // second copy without rom: only mode 1 may execute, no slave pins
  msd_top #(.ROM_PRESENT(0)) i_dut_norom (.mclk(mclk), .rst_b(rst_b), .mode_strap_high(hi),
    .mode_strap_low(lo), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(), .cpu_req(req), .cpu_addr(ca), .cpu_wait(wt), .cpu_done(),
    .cpu_void(), .cpu_region(), .io_page_strobe_n(), .addr_bus_en(),
    .data_bus_en(), .bus_ctrl_en(), .slave_en(slv2), .ext_master_ok(),
    .mode_valid(mval2), .op_mode());
  msd_ext_dev i_ext (.mclk(mclk), .rst_b(rst_b), .sel(req & (rgn == 3'd4)),
    .stall(stall), .wait_req(wt));
  task check(input [7:0] s, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
    end
  endtask
  // data stand only in the cycle after the strobe
  task rd(input [15:0] a, input [7:0] e);
    begin
      ra <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1 check(rdat, e);
      @(posedge mclk);
    end
  endtask
  // one cpu access; request dropped in the done cycle so it does not restart
  task acc(input [15:0] a, input [3:0] s, input [7:0] e);
    begin
      ca <= a;
      stall <= s;
      req <= 1'b1;
      n = 0;
      // first pass always waits an edge, so done is never read in the launch step
      while (n == 0 || (done !== 1'b1 && n < 20)) begin
        @(posedge mclk);
        #1 n = n + 1;
        check({7'd0, ios_n}, {7'd0, ~&a[15:8]});
      end
      req <= 1'b0;
      check(n[7:0], e);
      @(posedge mclk);
    end
  endtask
  function [2:0] exp_reg(input [1:0] md, input [15:0] a, input ram);
    begin
      if (a >= 16'hff90 && !(a >= 16'hffa8 && a <= 16'hffaf)) exp_reg = 3'd3;
      else if (a >= 16'hfd80 && a <= 16'hff7f && (ram || md == 2'd3)) exp_reg = 3'd2;
      else if (a <= 16'h3fff && md != 2'd1) exp_reg = 3'd1;
      else if (md == 2'd3) exp_reg = 3'd5;
      else exp_reg = 3'd4;
    end
  endfunction
  task wrap_up;
    begin
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // 8 ns clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // hang guard, far past the hundred or so cycles needed
  initial begin
    #100000;
    fail_count = fail_count + 1;
    wrap_up;
  end
  // one pass per strap setting, each behind its own reset
  initial begin
    fail_count = 0;
    cmp_count = 0;
    {rst_b, hi, lo, wr_s, rd_s, req} = 6'd0;
    {ra, ca, wd, stall} = 44'd0;
    for (m = 0; m < 4; m = m + 1) begin
      rst_b <= 1'b0;
      {hi, lo} <= m[1:0];
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      {hi, lo} <= ~m[1:0];
      rd(16'hffc5, {6'b111001, m[1:0]});
      check({6'd0, opm}, {6'd0, m[1:0]});
      wr(16'hffc5, 8'hff);
      rd(16'hffc5, {6'b111001, m[1:0]});
      rd(16'hffc4, 8'h09);
      rd(16'hff90, 8'h00);
      check({7'd0, mval}, {7'd0, m != 0});
      check({5'd0, abus, dbus, cbus}, {5'd0, {3{m == 1 || m == 2}}});
      wr(16'hffc4, 8'h0b);
      #1 check({6'd0, slv, xok}, {6'd0, {2{m == 3}}});
      check({6'd0, mval2, slv2}, {6'd0, m == 1, 1'b0});
      for (i = 0; i < 6 && m != 0; i = i + 1) begin
        ca <= tab[i*16 +: 16];
        @(posedge mclk);
        #1 check({5'd0, rgn}, {5'd0, exp_reg(m[1:0], ca, 1'b1)});
        check({7'd0, vd}, {7'd0, exp_reg(m[1:0], ca, 1'b1) == 3'd5});
      end
      if (m == 2) begin
        acc(16'hff90, 4'd0, 8'd3);
        acc(16'h0000, 4'd0, 8'd2);
        acc(16'hfd80, 4'd0, 8'd2);
        acc(16'h4000, 4'd0, 8'd3);
        acc(16'h4000, 4'd2, 8'd5);
        ca <= 16'hfd80;
        wr(16'hffc4, 8'h00);
        rd(16'hffc4, 8'h08);
        #1 check({5'd0, rgn}, {5'd0, exp_reg(2'd2, ca, 1'b0)});
      end
    end
    wrap_up;
  end
endmodule
